// [src/demux_bist_and_mode_select.sv]
// self-test pattern generator and static mode selection of the demux
`timescale 1ns/1ps
`default_nettype none
module demux_bist_and_mode_select #(
    parameter int CODE_WIDTH = 10,
    parameter int NUM_PORTS = 8
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic start_reset_async_i,
    input wire demux_bist_pkg::config_pins_t config_pins_i,
    output demux_bist_pkg::modes_t modes_o,
    output demux_bist_pkg::port_words_t port_words_o,
    output logic [demux_bist_pkg::PORTS_MAX-1:0] port_active_o,
    output logic word_valid_o
);
    import demux_bist_pkg::*;

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    modes_t modes;
    // pins are sampled as plain logic levels
    always_comb begin
        modes.ten_bit_words = config_pins_i.word_width_select;
        modes.full_rate_clock_mode = config_pins_i.clock_rate_select;
        modes.ratio_1to8 = ~config_pins_i.demux_ratio_select;
        modes.self_test_on = ~config_pins_i.self_test_select;
    end
    assign modes_o = modes;

    // ------------------------------------------------------------
    // start reset
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WAIT_PULSE,
        PULSE_HIGH,
        RUNNING
    } start_state_t;

    start_state_t start_state;
    start_state_t next_start_state;
    logic running;
    // a level held high keeps the generator parked; only the release
    // of the pulse lets the sequence start from the seed
    // next state of the start sequence
    always_comb begin
        next_start_state = start_state;
        case (start_state)
            WAIT_PULSE: begin
                if (start_reset_async_i) begin
                    next_start_state = PULSE_HIGH;
                end
            end
            PULSE_HIGH: begin
                if (!start_reset_async_i) begin
                    next_start_state = RUNNING;
                end
            end
            RUNNING: begin
                if (start_reset_async_i) begin
                    next_start_state = PULSE_HIGH;
                end
            end
            default: begin
                next_start_state = WAIT_PULSE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            start_state <= WAIT_PULSE;
        end else if (clk_en_i) begin
            start_state <= next_start_state;
        end
    end
    assign running = (start_state == RUNNING);

    // ------------------------------------------------------------
    // code generator, one code per sample clock
    // ------------------------------------------------------------
    logic [9:0] code;
    logic [9:0] next_code;
    logic [2:0] slot;
    logic [2:0] last_slot;
    logic [9:0] count;
    bist_code_step u_step (
        .code_i(code),
        .next_code_o(next_code)
    );
    assign last_slot = modes.ratio_1to8 ? 3'(NUM_PORTS - 1)
                                        : 3'(PORTS_NARROW - 1);
    logic gen;
    assign gen = running && modes.self_test_on;
    logic seq_wrap;
    // last code of the period: generator and slot restart together
    assign seq_wrap = (count == 10'(SEQ_LEN - 1));


    // advance on each sample clock edge
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            code <= SEED;
            count <= 10'h000;
        end else if (clk_en_i) begin
            if (!gen) begin
                code <= SEED;
                count <= 10'h000;
            end else if (seq_wrap) begin
                code <= SEED;
                count <= 10'h000;
            end else begin
                code <= next_code;
                count <= count + 10'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // distribution over ports
    // ------------------------------------------------------------
    port_words_t shadow;
    // seed always starts on port A
    // slot steps and wraps at the last active port
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            slot <= 3'h0;
        end else if (clk_en_i) begin
            if (!gen || slot == last_slot || seq_wrap) begin
                slot <= 3'h0;
            end else begin
                slot <= slot + 3'h1;
            end
        end
    end

    logic [9:0] shown;
    assign shown = modes.ten_bit_words ? code : (code & NARROW_MASK);

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            // only ports within the ratio take codes
            always_ff @(posedge clk_i) begin
                if (!reset_n_i) begin
                    shadow[p] <= '0;
                end else if (clk_en_i && gen && slot == 3'(p)) begin
                    shadow[p] <= shown;
                end
            end
        end
    endgenerate

    logic word_done;
    assign word_done = gen && (slot == last_slot);

    // ------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------
    // strobe marks the cycle in which the active ports change
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            word_valid_o <= 1'b0;
        end else if (clk_en_i) begin
            word_valid_o <= word_done;
        end
    end

    // the last slot's code is still in flight, so it bypasses shadow
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_out
            // all ports update together once per word
            always_ff @(posedge clk_i) begin
                if (!reset_n_i) begin
                    port_words_o[p] <= '0;
                end else if (clk_en_i && word_done) begin
                    if (3'(p) == last_slot) begin
                        port_words_o[p] <= shown;
                    end else if (3'(p) < last_slot) begin
                        port_words_o[p] <= shadow[p];
                    end else begin
                        // ports above the ratio read zero
                        port_words_o[p] <= '0;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // active port map
    // ------------------------------------------------------------
    // narrow ratio keeps only the low ports active
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_active
            assign port_active_o[p] = modes.ratio_1to8 || (p < PORTS_NARROW);
        end
    endgenerate
endmodule : demux_bist_and_mode_select
`default_nettype wire

// [src/demux_bist_pkg.sv]
// package: constants and carrier types for the self-test demultiplexer
package demux_bist_pkg;
    localparam int CODE_W = 10;
    localparam int PORTS_MAX = 8;
    localparam int PORTS_NARROW = 4;
    localparam int SEQ_LEN = 512;
    localparam logic [9:0] SEED = 10'h002;
    localparam int TAP_HI = 8;
    localparam int TAP_LO = 4;
    localparam logic [9:0] NARROW_MASK = 10'h0FF;

    typedef struct packed {
        logic demux_ratio_select;
        logic self_test_select;
        logic clock_rate_select;
        logic word_width_select;
    } config_pins_t;

    typedef struct packed {
        logic ratio_1to8;
        logic self_test_on;
        logic full_rate_clock_mode;
        logic ten_bit_words;
    } modes_t;

    typedef logic [PORTS_MAX-1:0][CODE_W-1:0] port_words_t;
endpackage : demux_bist_pkg

// [src/bist_code_step.sv]
// one step of the self-test pseudo-random code sequence
`timescale 1ns/1ps
`default_nettype none
module bist_code_step (
    input wire logic [9:0] code_i,
    output logic [9:0] next_code_o
);
    import demux_bist_pkg::*;
    assign next_code_o = {code_i[CODE_W-2:0],
                          code_i[TAP_HI] ^ code_i[TAP_LO]};
endmodule : bist_code_step
`default_nettype wire

// [test/far_side_model.sv]
// far-side model: jumper pins and start pulse source
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic ratio_i,
    input wire logic free_i,
    input wire demux_bist_pkg::config_pins_t raw_i,
    output demux_bist_pkg::config_pins_t pins_o,
    output logic start_o
);
    import demux_bist_pkg::*;
    assign pins_o = free_i ? raw_i : config_pins_t'({ratio_i, 3'b011});
    always_ff @(posedge clk_i) start_o <= go_i;
endmodule : far_side_model
`default_nettype wire

// [test/demux_bist_sva.sv]
// checker: port assertions of the self-test demux
`timescale 1ns/1ps
`default_nettype none
module demux_bist_sva import demux_bist_pkg::*; (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire config_pins_t config_pins_i,
    input wire modes_t modes_o,
    input wire port_words_t port_words_o,
    input wire logic [PORTS_MAX-1:0] port_active_o,
    input wire logic word_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    chk_ratio_decode: assert property (
        modes_o.ratio_1to8 != config_pins_i.demux_ratio_select) else
        $error("ratio decode wrong");
    chk_test_decode: assert property (
        modes_o.self_test_on != config_pins_i.self_test_select) else
        $error("self-test decode wrong");
    chk_width_decode: assert property (
        modes_o.ten_bit_words == config_pins_i.word_width_select) else
        $error("width decode wrong");
    chk_active_ports: assert property (port_active_o ==
        (config_pins_i.demux_ratio_select ? 8'h0F : 8'hFF)) else
        $error("active ports wrong");
    chk_code_step: assert property (word_valid_o && modes_o.ten_bit_words
        |-> port_words_o[1] == {port_words_o[0][8:0],
        port_words_o[0][8] ^ port_words_o[0][4]}) else $error("step wrong");
    chk_valid_pulse: assert property (word_valid_o
        |=> !word_valid_o [*3]) else $error("valid pulse wrong");
    chk_enable_freeze: assert property (!clk_en_i
        |=> $stable(port_words_o)) else $error("words moved");
    chk_unused_zero: assert property (word_valid_o &&
        config_pins_i.demux_ratio_select |-> port_words_o[7:4] == '0) else
        $error("unused ports not zero");
endmodule : demux_bist_sva
bind demux_bist_and_mode_select demux_bist_sva i_demux_bist_sva (.clk_i,
    .reset_n_i, .clk_en_i, .config_pins_i, .modes_o, .port_words_o,
    .port_active_o, .word_valid_o);
`default_nettype wire

// [test/tb.sv]
// testbench: self-test sequence, port spread and pin decode
`timescale 1ns/1ps
`default_nettype none
module tb;
    import demux_bist_pkg::*;
    logic clk_i = 0, reset_n_i = 0, clk_en_i = 1, go_i = 0, free_i = 0;
    logic ratio_i = 0, start_reset_async_i, word_valid_o;
    config_pins_t raw_i = '0, config_pins_i;
    modes_t modes_o;
    port_words_t port_words_o;
    logic [PORTS_MAX-1:0] port_active_o;
    logic [9:0] e;
    int n_errors = 0, cmp_count = 0;
    always #4 clk_i = ~clk_i;
    far_side_model i_far_side_model (.clk_i, .go_i, .ratio_i, .free_i,
        .raw_i, .pins_o(config_pins_i), .start_o(start_reset_async_i));
    demux_bist_and_mode_select i_demux_bist_and_mode_select (.clk_i,
        .reset_n_i, .clk_en_i, .start_reset_async_i, .config_pins_i,
        .modes_o, .port_words_o, .port_active_o, .word_valid_o);
    task automatic chk(string n, logic [9:0] s, logic [9:0] x);
        cmp_count++;
        if (s !== x) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic tick(int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic start_run(logic r);
        reset_n_i = 0;
        ratio_i = r;
        tick(2);
        reset_n_i = 1;
        go_i = 1;
        tick(1);
        go_i = 0;
        e = SEED;
    endtask : start_run
    task automatic word(int n, logic [9:0] m = 10'h3FF);
        int i;
        i = 0;
        while (word_valid_o !== 1'b1 && i < 40) begin
            tick(1);
            i++;
        end
        chk("valid", word_valid_o, 1'b1);
        for (i = 0; i < 8; i++) begin
            chk("port", port_words_o[i], i < n ? e & m : 10'h000);
            if (i < n) e = {e[8:0], e[8] ^ e[4]};
        end
        tick(1);
    endtask : word
    task automatic tally_and_finish();
        if (n_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        #20000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        start_run(0);
        word(8);
        clk_en_i = 0;
        tick(5);
        clk_en_i = 1;
        word(8);
        start_run(1);
        word(4);
        word(4);
        free_i = 1;
        raw_i = config_pins_t'(4'h2);
        start_run(0);
        word(8, NARROW_MASK);
        reset_n_i = 0;
        free_i = 1;
        for (int k = 0; k < 16; k++) begin
            raw_i = config_pins_t'(k[3:0]);
            tick(1);
            chk("modes", modes_o, {~raw_i[3:2], raw_i[1:0]});
            chk("active", port_active_o, raw_i[3] ? 8'h0F : 8'hFF);
        end
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
